// ### rtl/wffc_pkg.sv
`default_nettype none
package wffc_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] OFS_LOW_MASK = 7'h2A;
  localparam logic [6:0] OFS_LEN_CODE = 7'h2B;
  localparam logic [6:0] OFS_BYTE7 = 7'h2C;
  localparam logic [6:0] OFS_BYTE6 = 7'h2D;
  localparam logic [6:0] OFS_BYTE5 = 7'h2E;
  localparam logic [6:0] OFS_BYTE4 = 7'h2F;
  localparam int MASK_LSB = 2;
  localparam int MASK_W = 5;
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 4;
  localparam logic [4:0] RST_MASK = 5'h00;
  localparam logic [3:0] RST_LEN = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam int FIRST_UPPER_BYTE = 4;
  localparam int UPPER_BYTES = 4;

  typedef struct packed {
    logic [4:0] low_identifier_compare_select;
    logic [3:0] len_code;
    logic [3:0][7:0] payload_hi;
  } wffc_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wffc_req_t;

  typedef struct packed {
    logic valid;
    logic ide;
    logic [3:0] len_code;
    logic [4:0] low_identifier_bits;
    logic [4:0] exp_low_identifier_bits;
    logic [3:0][7:0] payload_hi;
  } wffc_rx_t;
endpackage
`default_nettype wire

// ### rtl/wffc_top.sv
`default_nettype none
module wffc_top (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic restart,
  // register port
  input wire wffc_pkg::wffc_req_t req,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // configuration to comparator
  output wffc_pkg::wffc_cfg_t cfg_r,
  output logic [3:0] byte_count_r,
  output logic [3:0] byte_cmp_en_r,
  // partial wake_up_frame check
  input wire wffc_pkg::wffc_rx_t rx,
  output logic part_valid_r,
  output logic part_match_r
);
  wffc_pkg::wffc_cfg_t cfg_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic [3:0] count_nxt;
  logic [3:0] en_nxt;
  logic pv_nxt;
  logic pm_nxt;
  logic len_ok;
  logic id_ok;
  logic data_ok;
  logic [1:0] bidx;
  logic [1:0] rbidx;

  // write path; stored fields hold only used bits, so unused bits cannot stick
  always_comb begin
    cfg_nxt = cfg_r;
    bidx = 2'(wffc_pkg::OFS_BYTE4 - req.addr);
    if (soft_rst) begin
      cfg_nxt.low_identifier_compare_select = wffc_pkg::RST_MASK;
      cfg_nxt.len_code = wffc_pkg::RST_LEN;
      cfg_nxt.payload_hi = {wffc_pkg::UPPER_BYTES{wffc_pkg::RST_BYTE}};
    end else if (req.wr) begin
      case (req.addr)
        wffc_pkg::OFS_LOW_MASK: begin
          cfg_nxt.low_identifier_compare_select =
            req.wdata[wffc_pkg::MASK_LSB +: wffc_pkg::MASK_W];
        end
        wffc_pkg::OFS_LEN_CODE: begin
          cfg_nxt.len_code = req.wdata[wffc_pkg::LEN_LSB +: wffc_pkg::LEN_W];
        end
        wffc_pkg::OFS_BYTE7, wffc_pkg::OFS_BYTE6, wffc_pkg::OFS_BYTE5,
        wffc_pkg::OFS_BYTE4: begin
          cfg_nxt.payload_hi[bidx] = req.wdata;
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
    // restart leaves every stored field alone
    if (restart && !soft_rst) begin
      cfg_nxt = cfg_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // a write that meets soft reset or restart is dropped, so those cycles are excluded
  mask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && !soft_rst && !restart && req.addr == wffc_pkg::OFS_LOW_MASK
    |=> cfg_r.low_identifier_compare_select == $past(req.wdata[6:2]))
    else $error("mask write lost");
  len_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && !soft_rst && !restart && req.addr == wffc_pkg::OFS_LEN_CODE
    |=> cfg_r.len_code == $past(req.wdata[3:0]))
    else $error("length code write lost");
  byte_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && !soft_rst && !restart && req.addr == wffc_pkg::OFS_BYTE7
    |=> cfg_r.payload_hi[3] == $past(req.wdata))
    else $error("byte seven write lost");
  soft_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    soft_rst |=> cfg_r == '0)
    else $error("soft reset did not clear");
  restart_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    restart && !soft_rst |=> $stable(cfg_r))
    else $error("restart changed config");

  // read path; unmapped addresses return zero
  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = req.rd;
    rbidx = 2'(wffc_pkg::OFS_BYTE4 - req.addr);
    if (req.rd) begin
      case (req.addr)
        wffc_pkg::OFS_LOW_MASK: begin
          rdata_nxt = {1'h0, cfg_r.low_identifier_compare_select, 2'h0};
        end
        wffc_pkg::OFS_LEN_CODE: begin
          rdata_nxt = {4'h0, cfg_r.len_code};
        end
        wffc_pkg::OFS_BYTE7, wffc_pkg::OFS_BYTE6, wffc_pkg::OFS_BYTE5,
        wffc_pkg::OFS_BYTE4: begin
          rdata_nxt = cfg_r.payload_hi[rbidx];
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'h0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  mask_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rvalid_r && $past(req.addr) == wffc_pkg::OFS_LOW_MASK |-> (rdata_r & 8'h83) == 8'h00)
    else $error("reserved mask bits read nonzero");
  len_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rvalid_r && $past(req.addr) == wffc_pkg::OFS_LEN_CODE |-> rdata_r[7:4] == 4'h0)
    else $error("reserved length bits read nonzero");
  // a read in the same cycle as a write returns the old value
  byte_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rvalid_r && $past(req.addr) == wffc_pkg::OFS_BYTE7
    |-> rdata_r == $past(cfg_r.payload_hi[3]))
    else $error("byte seven read wrong");

  // derived length and per-byte enables, taken from the next config
  always_comb begin
    count_nxt = cfg_nxt.len_code[3] ? wffc_pkg::MAX_BYTES : cfg_nxt.len_code;
    for (int i = 0; i < wffc_pkg::UPPER_BYTES; i++) begin
      en_nxt[i] = (count_nxt > 4'(wffc_pkg::FIRST_UPPER_BYTE + i));
    end
  end

  // registered with cfg_r, so the count never lags the stored code
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_count_r <= 4'h0;
      byte_cmp_en_r <= 4'h0;
    end else begin
      byte_count_r <= count_nxt;
      byte_cmp_en_r <= en_nxt;
    end
  end

  len_clamp_a: assert property (@(posedge clk_sys) disable iff (rst)
    byte_count_r == (cfg_r.len_code[3] ? wffc_pkg::MAX_BYTES : cfg_r.len_code))
    else $error("byte count wrong");
  byte_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    byte_count_r <= 4'h4 |-> byte_cmp_en_r == 4'h0)
    else $error("upper byte enabled for short frame");
  full_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    byte_count_r == wffc_pkg::MAX_BYTES |-> byte_cmp_en_r == 4'hF)
    else $error("upper byte disabled for full frame");

  // partial comparison: length code, low identifier bits, upper bytes
  always_comb begin
    len_ok = (rx.len_code == cfg_r.len_code);
    // a standard identifier lives in bits 28:18, so low bits are skipped
    id_ok = !rx.ide || (((rx.low_identifier_bits ^ rx.exp_low_identifier_bits) &
             cfg_r.low_identifier_compare_select) == 5'h00);
    data_ok = 1'h1;
    for (int i = 0; i < wffc_pkg::UPPER_BYTES; i++) begin
      if (byte_cmp_en_r[i] && (rx.payload_hi[i] != cfg_r.payload_hi[i])) begin
        data_ok = 1'h0;
      end
    end
    pv_nxt = rx.valid;
    pm_nxt = rx.valid && len_ok && id_ok && data_ok;
  end

  // frames are judged against stored config only, so a write takes effect one cycle on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      part_valid_r <= 1'h0;
      part_match_r <= 1'h0;
    end else begin
      part_valid_r <= pv_nxt;
      part_match_r <= pm_nxt;
    end
  end

  exact_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx.valid && rx.len_code != cfg_r.len_code |=> !part_match_r)
    else $error("match with different length code");
  match_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    part_match_r |-> part_valid_r)
    else $error("match without a frame");
  mask_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx.valid && rx.ide && ((rx.low_identifier_bits ^ rx.exp_low_identifier_bits) &
    cfg_r.low_identifier_compare_select) != 5'h00 |=> !part_match_r)
    else $error("masked id mismatch accepted");
  id_match_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx.valid && rx.ide && rx.len_code == cfg_r.len_code && byte_cmp_en_r == 4'h0 &&
    ((rx.low_identifier_bits ^ rx.exp_low_identifier_bits) &
    cfg_r.low_identifier_compare_select) == 5'h00 |=> part_match_r)
    else $error("masked id match rejected");
  std_id_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx.valid && !rx.ide && rx.len_code == cfg_r.len_code && byte_cmp_en_r == 4'h0
    |=> part_match_r)
    else $error("standard frame rejected on low bits");
  data_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx.valid && byte_cmp_en_r[0] && rx.payload_hi[0] != cfg_r.payload_hi[0]
    |=> !part_match_r)
    else $error("enabled byte four mismatch accepted");
  match_c: cover property (@(posedge clk_sys) disable iff (rst) part_match_r);
  long_c: cover property (@(posedge clk_sys) disable iff (rst) cfg_r.len_code == 4'hF);
  restart_c: cover property (@(posedge clk_sys) disable iff (rst)
    restart && cfg_r != '0);
  std_c: cover property (@(posedge clk_sys) disable iff (rst)
    rx.valid && !rx.ide ##1 part_match_r);
  soft_c: cover property (@(posedge clk_sys) disable iff (rst) soft_rst && cfg_r != '0);
endmodule
`default_nettype wire

// ### tb/wffc_host.sv
`default_nettype none
module wffc_host (
  // clock
  input wire logic clk_sys,
  // register port
  output var wffc_pkg::wffc_req_t req,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // strobes held across one whole edge, dropped only after it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) #1;
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) #1;
    d = rdata_r;
    v = rvalid_r;
    req.rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/test_wake_frame_filter_config.sv
`default_nettype none
module test_wake_frame_filter_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  wffc_pkg::wffc_req_t req;
  wffc_pkg::wffc_rx_t rx = '0;
  wffc_pkg::wffc_cfg_t cfg_r;
  logic [7:0] rdata_r;
  logic [3:0] byte_count_r;
  logic [3:0] byte_cmp_en_r;
  logic rvalid_r;
  logic part_valid_r;
  logic part_match_r;
  int miscompares = 0;
  int checks = 0;
  logic [31:0] ph = 32'h81422418;
  wffc_top u_dut (.clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .restart(restart),
    .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .cfg_r(cfg_r),
    .byte_count_r(byte_count_r), .byte_cmp_en_r(byte_cmp_en_r), .rx(rx),
    .part_valid_r(part_valid_r), .part_match_r(part_match_r));
  wffc_host u_host (.clk_sys(clk_sys), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    cmp("rvalid", 8'h01, {7'h00, v});
    cmp("rdata", e, d);
  endtask
  task automatic frm(input logic ide, input logic [3:0] len, input logic [4:0] id,
    input logic [4:0] eid, input logic [31:0] p, input logic e);
    @(posedge clk_sys) #1;
    rx = '{valid: 1'b1, ide: ide, len_code: len, low_identifier_bits: id,
      exp_low_identifier_bits: eid, payload_hi: p};
    @(posedge clk_sys) #1;
    rx.valid = 1'b0;
    cmp("part_valid", 8'h01, {7'h00, part_valid_r});
    cmp("part_match", {7'h00, e}, {7'h00, part_match_r});
  endtask
  task automatic pulse(input logic s);
    @(posedge clk_sys) #1;
    if (s) soft_rst = 1'b1;
    else restart = 1'b1;
    @(posedge clk_sys) #1;
    soft_rst = 1'b0;
    restart = 1'b0;
  endtask
  // all values land well inside this span; a hang is cut short here
  initial begin
    #100us;
    miscompares++;
    test_done();
  end
  initial begin
    logic [3:0] n;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int a = 8'h2A; a <= 8'h2F; a++) rchk(a[6:0], 8'h00);
    rchk(7'h30, 8'h00);
    $display("reset test done");
    u_host.wr(7'h2A, 8'hFF);
    u_host.wr(7'h2B, 8'hFF);
    for (int i = 0; i < 4; i++) u_host.wr(7'h2C + i[6:0], ph[31 - 8 * i -: 8]);
    rchk(7'h2A, 8'h7C);
    rchk(7'h2B, 8'h0F);
    for (int i = 0; i < 4; i++) rchk(7'h2C + i[6:0], ph[31 - 8 * i -: 8]);
    cmp("byte7", 8'h81, cfg_r.payload_hi[3]);
    $display("access test done");
    for (int c = 0; c < 16; c++) begin
      u_host.wr(7'h2B, c[7:0]);
      n = (c > 8) ? 4'h8 : c[3:0];
      cmp("count", {4'h0, n}, {4'h0, byte_count_r});
      for (int i = 0; i < 4; i++)
        cmp("cmp_en", {7'h00, n > 4 + i}, {7'h00, byte_cmp_en_r[i]});
    end
    pulse(1'b0);
    rchk(7'h2A, 8'h7C);
    rchk(7'h2B, 8'h0F);
    rchk(7'h2C, 8'h81);
    $display("length and restart test done");
    u_host.wr(7'h2B, 8'h08);
    frm(1'b1, 4'h8, 5'h03, 5'h03, ph, 1'b1);
    frm(1'b1, 4'hF, 5'h03, 5'h03, ph, 1'b0);
    frm(1'b1, 4'h8, 5'h03, 5'h05, ph, 1'b0);
    frm(1'b0, 4'h8, 5'h03, 5'h05, ph, 1'b1);
    u_host.wr(7'h2A, 8'h00);
    u_host.wr(7'h2B, 8'h05);
    frm(1'b1, 4'h5, 5'h03, 5'h05, ph ^ 32'hFF000000, 1'b1);
    frm(1'b1, 4'h5, 5'h03, 5'h05, ph ^ 32'h000000FF, 1'b0);
    u_host.wr(7'h2B, 8'h04);
    frm(1'b0, 4'h4, 5'h03, 5'h05, ~ph, 1'b1);
    frm(1'b1, 4'h4, 5'h03, 5'h05, ~ph, 1'b1);
    $display("frame test done");
    u_host.wr(7'h2A, 8'h7C);
    pulse(1'b1);
    for (int a = 8'h2A; a <= 8'h2F; a++) rchk(a[6:0], 8'h00);
    $display("soft reset test done");
    u_host.wr(7'h2C, 8'hA5);
    @(posedge clk_sys) #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    rchk(7'h2C, 8'h00);
    $display("power-on reset test done");
    test_done();
  end
endmodule
`default_nettype wire
